/* File: logic/i2cms_regs.vh */
// Functional notes
// - with slave enabled, watch every start and receive or send as addressed
// - with master enabled, drive start and stop and begin transfers itself
// - as one of several masters, follow the shared clock and arbitrate
// - master enabled, slave disabled: foreign starts raise no event
// - received 7-bit address compared with own address in hardware
// - own address match while in low power raises a wake request
// - after start: 7 address bits then direction bit, 0 write, 1 read
// - a master may issue a repeated start instead of stop
// - bus rates from standard up to 1 Mbps via clock divider
// - digital glitch filter only while awake, bypassed while sleeping
// - framing and bus status handled in hardware, cpu works per byte
// - events shown as pollable status and as an event line
`ifndef I2CMS_REGS_VH
`define I2CMS_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define I2CMS_ADDR_CFG   4'h0
`define I2CMS_ADDR_OWN   4'h1
`define I2CMS_ADDR_DIV   4'h2
`define I2CMS_ADDR_DATA  4'h3
`define I2CMS_ADDR_CMD   4'h4
`define I2CMS_ADDR_STAT  4'h5

// ****************************************
// field positions
// ****************************************
`define I2CMS_CFG_SLV    0
`define I2CMS_CFG_MST    1
`define I2CMS_CMD_START  0
`define I2CMS_CMD_STOP   1
`define I2CMS_CMD_XFER   2
`define I2CMS_CMD_NACK   3
`define I2CMS_ST_DONE    0
`define I2CMS_ST_HIT     1
`define I2CMS_ST_LOST    2
`define I2CMS_ST_STOP    3

// ****************************************
// timing
// ****************************************
`define I2CMS_CLK_KHZ    50000
`define I2CMS_STD_KHZ    100
`define I2CMS_DIV_RST    (`I2CMS_CLK_KHZ / (2 * `I2CMS_STD_KHZ))

`endif

/* File: logic/i2cms_ctrl.v */
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "i2cms_regs.vh"
module i2cms_ctrl
(
    input  wire       clk_sys,
    input  wire       sys_rst,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       sleep_mode,
    input  wire       scl_in,
    output reg        scl_out,
    output reg        scl_oe,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    output reg        event_pend,
    output reg        wake_req
);

// ****************************************
// states
// ****************************************
localparam [4:0] S_IDLE   = 5'h01;
localparam [4:0] S_ADDR   = 5'h02;
localparam [4:0] S_DATA   = 5'h04;
localparam [4:0] S_WAIT   = 5'h08;
localparam [4:0] S_SKIP   = 5'h10;
localparam [3:0] MP_OFF   = 4'h1;
localparam [3:0] MP_SETUP = 4'h2;
localparam [3:0] MP_SDA   = 4'h4;
localparam [3:0] MP_RUN   = 4'h8;
// divider reset value, kept at full width so that only its low byte is taken
localparam [31:0] DIV_RST_W = `I2CMS_DIV_RST;

// ****************************************
// storage
// ****************************************
reg  [1:0] sync1;
reg  [1:0] sync2;
reg  [1:0] hist1;
reg  [1:0] hist2;
reg  [1:0] bus_f;
reg  [1:0] bus_p;
reg        slv_en;
reg        mst_en;
reg  [6:0] own_addr;
reg  [7:0] div;
reg  [7:0] tx_byte;
reg  [7:0] rx_byte;
reg  [7:0] shreg;
reg  [3:0] bit_cnt;
reg  [7:0] mcnt;
reg  [4:0] state;
reg  [3:0] mphase;
reg        first;
reg        xmit;
reg        dir;
reg        nack;
reg        mst;
reg        stopping;
reg        busy;
reg        byte_done;
reg        addr_hit;
reg        lost;
reg        stop_seen;
reg        ack_bit;
wire [1:0] stable;
wire       scl_f;
wire       sda_f;
wire       scl_rise;
wire       scl_fall;
wire       start_det;
wire       stop_det;
wire       cmd_wr;
wire       in_byte;

// ****************************************
// input sampling and glitch filter
// ****************************************
// bit 1 is scl, bit 0 is sda; while awake a level is taken only after three equal samples
assign stable = ~(sync2 ^ hist1) & ~(hist1 ^ hist2);

always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        sync1 <= 2'h3;
        sync2 <= 2'h3;
        hist1 <= 2'h3;
        hist2 <= 2'h3;
        bus_f <= 2'h3;
        bus_p <= 2'h3;
    end
    else
    begin
        sync1 <= {scl_in, sda_in};
        sync2 <= sync1;
        hist1 <= sync2;
        hist2 <= hist1;
        if (sleep_mode)
            bus_f <= sync2;
        else
            bus_f <= (stable & sync2) | (~stable & bus_f);
        bus_p <= bus_f;
    end
end

// bus events seen on filtered lines
assign scl_f     = bus_f[1];
assign sda_f     = bus_f[0];
assign scl_rise  = scl_f & ~bus_p[1];
assign scl_fall  = ~scl_f & bus_p[1];
assign start_det = scl_f & bus_p[1] & bus_p[0] & ~sda_f;
assign stop_det  = scl_f & bus_p[1] & ~bus_p[0] & sda_f;
assign cmd_wr    = reg_wr && (reg_addr == `I2CMS_ADDR_CMD);
assign in_byte   = (state == S_ADDR) || (state == S_DATA);

// ****************************************
// configuration registers
// ****************************************
always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        slv_en   <= 1'b0;
        mst_en   <= 1'b0;
        own_addr <= 7'h00;
        div      <= DIV_RST_W[7:0];
        tx_byte  <= 8'h00;
    end
    else if (reg_wr)
    begin
        case (reg_addr)
            `I2CMS_ADDR_CFG:
            begin
                slv_en <= reg_wdata[`I2CMS_CFG_SLV];
                mst_en <= reg_wdata[`I2CMS_CFG_MST];
            end
            `I2CMS_ADDR_OWN:  own_addr <= reg_wdata[6:0];
            `I2CMS_ADDR_DIV:  div <= reg_wdata;
            `I2CMS_ADDR_DATA: tx_byte <= reg_wdata;
            default:          tx_byte <= tx_byte;
        endcase
    end
end

// ****************************************
// read port
// ****************************************
always @(posedge clk_sys)
begin
    if (sys_rst)
        reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
        case (reg_addr)
            `I2CMS_ADDR_CFG:  reg_rdata <= {6'h00, mst_en, slv_en};
            `I2CMS_ADDR_OWN:  reg_rdata <= {1'b0, own_addr};
            `I2CMS_ADDR_DIV:  reg_rdata <= div;
            `I2CMS_ADDR_DATA: reg_rdata <= rx_byte;
            `I2CMS_ADDR_STAT: reg_rdata <= {mst, dir, busy, ack_bit,
                                            stop_seen, lost, addr_hit, byte_done};
            default:          reg_rdata <= 8'h00;
        endcase
    end
    else
        reg_rdata <= 8'h00;
end

// ****************************************
// byte engine and master sequencer
// ****************************************
// cpu actions come first so that a bus event in the same cycle wins
always @(posedge clk_sys)
begin
    if (sys_rst)
    begin
        scl_out    <= 1'b0;
        sda_out    <= 1'b0;
        scl_oe     <= 1'b0;
        sda_oe     <= 1'b0;
        event_pend <= 1'b0;
        wake_req   <= 1'b0;
        rx_byte    <= 8'h00;
        shreg      <= 8'h00;
        bit_cnt    <= 4'h0;
        mcnt       <= 8'h00;
        state      <= S_IDLE;
        mphase     <= MP_OFF;
        first      <= 1'b0;
        xmit       <= 1'b0;
        dir        <= 1'b0;
        nack       <= 1'b0;
        mst        <= 1'b0;
        stopping   <= 1'b0;
        busy       <= 1'b0;
        byte_done  <= 1'b0;
        addr_hit   <= 1'b0;
        lost       <= 1'b0;
        stop_seen  <= 1'b0;
        ack_bit    <= 1'b0;
    end
    else
    begin
        scl_out <= 1'b0;                                     // open drain: only pulls low
        sda_out <= 1'b0;
        // status clears, write one to clear
        if (reg_wr && reg_addr == `I2CMS_ADDR_STAT)
        begin
            addr_hit  <= addr_hit & ~reg_wdata[`I2CMS_ST_HIT];
            lost      <= lost & ~reg_wdata[`I2CMS_ST_LOST];
            stop_seen <= stop_seen & ~reg_wdata[`I2CMS_ST_STOP];
        end
        if (!sleep_mode)
            wake_req <= 1'b0;
        // start or repeated start request
        if (cmd_wr && reg_wdata[`I2CMS_CMD_START] && mst_en &&
            (!busy || (mst && state == S_WAIT)))
        begin
            shreg     <= tx_byte;
            mst       <= 1'b1;
            stopping  <= 1'b0;
            sda_oe    <= 1'b0;
            mcnt      <= 8'h00;
            mphase    <= MP_SETUP;
            byte_done <= 1'b0;
        end
        else if (cmd_wr && reg_wdata[`I2CMS_CMD_STOP] && mst && state == S_WAIT)
        begin
            sda_oe    <= 1'b1;
            stopping  <= 1'b1;
            mcnt      <= 8'h00;
            mphase    <= MP_SETUP;
            byte_done <= 1'b0;
        end
        else if (cmd_wr && reg_wdata[`I2CMS_CMD_XFER] && state == S_WAIT)
        begin
            state     <= S_DATA;
            bit_cnt   <= 4'h0;
            first     <= 1'b0;
            byte_done <= 1'b0;
            nack      <= reg_wdata[`I2CMS_CMD_NACK];
            if (xmit)
                shreg <= tx_byte;
            sda_oe    <= xmit & ~tx_byte[7];
        end
        // slave lets go of the clock one cycle after data is set up
        if (!mst && scl_oe && state == S_DATA)
            scl_oe <= 1'b0;
        // master clock and framing generation
        case (mphase)
            MP_SETUP:
            begin
                scl_oe <= 1'b0;
                if (scl_f)
                begin
                    if (mcnt == div)
                    begin
                        mcnt <= 8'h00;
                        if (stopping)
                        begin
                            sda_oe <= 1'b0;
                            mst    <= 1'b0;
                            mphase <= MP_OFF;
                        end
                        else
                        begin
                            sda_oe <= 1'b1;
                            mphase <= MP_SDA;
                        end
                    end
                    else
                        mcnt <= mcnt + 8'h01;
                end
            end
            MP_SDA:
            begin
                if (mcnt == div)
                begin
                    scl_oe <= 1'b1;
                    mcnt   <= 8'h00;
                    mphase <= MP_RUN;
                end
                else
                    mcnt <= mcnt + 8'h01;
            end
            MP_RUN:
            begin
                if (state == S_WAIT)
                begin
                    scl_oe <= 1'b1;
                    mcnt   <= 8'h00;
                end
                else if (scl_oe)
                begin
                    if (mcnt == div)
                    begin
                        scl_oe <= 1'b0;
                        mcnt   <= 8'h00;
                    end
                    else
                        mcnt <= mcnt + 8'h01;
                end
                else if (scl_f)
                begin
                    if (mcnt == div)
                    begin
                        scl_oe <= 1'b1;
                        mcnt   <= 8'h00;
                    end
                    else
                        mcnt <= mcnt + 8'h01;
                end
                else if (mcnt != 8'h00)
                begin
                    scl_oe <= 1'b1;
                    mcnt   <= 8'h00;
                end
            end
            default:
                mcnt <= 8'h00;
        endcase
        // bus framing and bit handling
        if (stop_det)
        begin
            if (state != S_IDLE && state != S_SKIP)
                stop_seen <= 1'b1;
            state <= S_IDLE;
            busy  <= 1'b0;
        end
        else if (start_det)
        begin
            busy    <= 1'b1;
            first   <= 1'b1;
            bit_cnt <= 4'h0;
            xmit    <= mst;
            if (mst || slv_en)
                state <= S_ADDR;
            else
                state <= S_SKIP;
        end
        else if (in_byte && scl_rise)
        begin
            if (bit_cnt[3])
                ack_bit <= sda_f;
            else
            begin
                shreg <= {shreg[6:0], sda_f};
                if (mst && xmit && !sda_oe && !sda_f)
                begin
                    lost   <= 1'b1;
                    mst    <= 1'b0;
                    xmit   <= 1'b0;
                    mphase <= MP_OFF;
                    scl_oe <= 1'b0;
                    state  <= (state == S_ADDR && slv_en) ? S_ADDR : S_SKIP;
                end
            end
        end
        else if (in_byte && scl_fall)
        begin
            if (first)
            begin
                first  <= 1'b0;
                sda_oe <= xmit & ~shreg[7];
            end
            else if (bit_cnt == 4'h7)
            begin
                bit_cnt <= 4'h8;
                rx_byte <= shreg;
                if (state == S_ADDR)
                begin
                    dir <= shreg[0];
                    if (mst)
                        sda_oe <= 1'b0;
                    else if (shreg[7:1] == own_addr)
                    begin
                        sda_oe   <= 1'b1;
                        addr_hit <= 1'b1;
                        if (sleep_mode)
                            wake_req <= 1'b1;
                    end
                    else
                    begin
                        sda_oe <= 1'b0;
                        state  <= S_SKIP;
                    end
                end
                else
                    sda_oe <= ~xmit & ~nack;
            end
            else if (bit_cnt == 4'h8)
            begin
                sda_oe    <= 1'b0;
                state     <= S_WAIT;
                byte_done <= 1'b1;
                scl_oe    <= 1'b1;
                if (state == S_ADDR)
                    xmit <= mst ? ~dir : dir;
            end
            else
            begin
                bit_cnt <= bit_cnt + 4'h1;
                sda_oe  <= xmit & ~shreg[7];
            end
        end
        event_pend <= byte_done | addr_hit | lost | stop_seen;
    end
end

endmodule

/* File: tb/i2cms_checker.sv */
`timescale 1ns/1ps
`include "i2cms_regs.vh"
module i2cms_checker
(
    input wire       clk_sys,
    input wire       sys_rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       sleep_mode,
    input wire       scl_in,
    input wire       scl_out,
    input wire       scl_oe,
    input wire       sda_in,
    input wire       sda_out,
    input wire       sda_oe,
    input wire       event_pend,
    input wire       wake_req
);
    reg [1:0] cfg;
    reg       mst_idle;
    // ********************
    // enable shadow; master only, slave disabled, and no command yet
    // ********************
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cfg      <= 2'b00;
            mst_idle <= 1'b0;
        end
        else if (reg_wr && reg_addr == `I2CMS_ADDR_CFG)
        begin
            cfg      <= reg_wdata[1:0];
            mst_idle <= reg_wdata[1:0] == 2'b10;
        end
        else if (reg_wr && reg_addr == `I2CMS_ADDR_CMD)
        begin
            mst_idle <= 1'b0;
        end
    end
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // ********************
    // properties
    // ********************
    chk_reset_quiet: assert property ( // quiet after reset
        $past(sys_rst) |-> !scl_oe && !sda_oe && !event_pend && !wake_req)
        else $error("output active after reset");
    chk_rdata_idle: assert property ( // read data only after a read
        reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data without read");
    chk_drive_low: assert property ( // open drain
        !scl_out && !sda_out)
        else $error("line driven high");
    chk_wake_awake: assert property ( // wake drops when awake
        !sleep_mode |=> !wake_req)
        else $error("wake while awake");
    chk_wake_cause: assert property ( // wake only asleep as slave
        $rose(wake_req) |-> $past(sleep_mode) && cfg[0])
        else $error("wake without cause");
    chk_idle_quiet: assert property ( // disabled block leaves bus
        cfg == 2'b00 |-> !scl_oe && !sda_oe)
        else $error("disabled block drives bus");
    chk_master_quiet: assert property ( // no event on foreign start
        mst_idle |-> !event_pend && !scl_oe && !sda_oe)
        else $error("idle master reacts");
    chk_stretch_hold: assert property ( // clock held until serviced
        cfg == 2'b01 && scl_oe && !reg_wr && !$past(reg_wr) && !$past(reg_wr, 2)
        |=> scl_oe)
        else $error("stretch released early");
    cover property (wake_req);
    cover property (cfg == 2'b01 && scl_oe);
    cover property (cfg[1] && scl_oe && sda_oe);
endmodule

bind i2cms_ctrl i2cms_checker i2cms_checker_i
(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .event_pend(event_pend), .wake_req(wake_req)
);

/* File: tb/i2cms_peer.sv */
`timescale 1ns/1ps
module i2cms_peer
(
    input  wire scl,
    input  wire sda,
    output reg  scl_low,
    output reg  sda_low
);
    reg x;
    // both lines released at start
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // start on idle bus: data falls with clock high
    task mstart;
        begin
            #3 sda_low = 1'b1;
            #80 scl_low = 1'b1;
        end
    endtask
    // one bit as master, waits out a held clock
    task mbit(input b, input integer lo, output r);
        begin
            #20 sda_low = ~b; // data moves in low phase only
            #(lo - 20) scl_low = 1'b0;
            wait (scl); // follows a stretched clock
            #43 r = sda;
            #40 scl_low = 1'b1;
        end
    endtask
    // byte msb first, then the receiver's bit
    task mbyte(input [7:0] v, output ack);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
            begin
                mbit(v[i], 80, x); // msb first
            end
            mbit(1'b1, 160, ack); // line freed for ack
        end
    endtask
    // stop: data rises with clock high
    task mstop;
        begin
            #20 sda_low = 1'b1;
            #60 scl_low = 1'b0;
            wait (scl);
            #43 sda_low = 1'b0; // master ends transfer
            #200; // let the block see the stop before status is read
        end
    endtask
    // receive a byte from the block as master
    task sbyte(input st, output [7:0] v);
        integer i;
        begin
            if (st)
            begin
                @(negedge sda iff scl);
            end
            for (i = 0; i < 8; i = i + 1)
            begin
                @(posedge scl) v = {v[6:0], sda};
            end
            @(negedge scl) #20 sda_low = 1'b1; // receiver acks
            @(negedge scl) #20 sda_low = 1'b0;
        end
    endtask
    // data pulse narrower than three samples on an idle bus
    task glitch;
        begin
            #3 sda_low = 1'b1;
            #30 sda_low = 1'b0; // must be filtered while awake
        end
    endtask
    task sstop;
        begin
            @(posedge sda iff scl);
        end
    endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "i2cms_regs.vh"
module tb;
    localparam [7:0] cmd_start = 8'h01 << `I2CMS_CMD_START;
    localparam [7:0] cmd_stop  = 8'h01 << `I2CMS_CMD_STOP;
    localparam [7:0] cmd_xfer  = 8'h01 << `I2CMS_CMD_XFER;
    reg         clk_sys;
    reg         sys_rst;
    reg  [3:0]  reg_addr;
    reg  [7:0]  reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    reg         sleep_mode;
    wire [7:0]  reg_rdata;
    wire        scl_oe;
    wire        sda_oe;
    wire        event_pend;
    wire        wake_req;
    wire        scl_low;
    wire        sda_low;
    wire        scl = ~(scl_oe | scl_low); // pulled up unless held low
    wire        sda = ~(sda_oe | sda_low);
    integer     fail_count;
    integer     n_compared;
    integer     cycles;
    integer     k;
    reg  [31:0] rnd;
    reg  [7:0]  d;
    reg  [7:0]  st;
    reg  [6:0]  own;
    reg  [6:0]  sent;
    reg         ack;
    i2cms_ctrl i2cms_ctrl_i
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
        .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .event_pend(event_pend), .wake_req(wake_req)
    );
    i2cms_peer i2cms_peer_i
    (
        .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low)
    );
    // ********************
    // helpers
    // ********************
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] addr_byte(input [6:0] a, input rw);
        addr_byte = {a, rw}; // 7-bit form only, longer ones are firmware's
    endfunction
    function [7:0] exp_rst(input [3:0] a);
        exp_rst = (a == `I2CMS_ADDR_DIV) ? 8'(`I2CMS_DIV_RST) : 8'h00;
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp)
            begin
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
                fail_count = fail_count + 1;
            end
        end
    endtask
    task wr(input [3:0] a, input [7:0] v);
        begin
            @(posedge clk_sys);
            reg_addr  <= a;
            reg_wdata <= v;
            reg_wr    <= 1'b1;
            @(posedge clk_sys);
            reg_wr    <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, output [7:0] v);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge clk_sys);
            reg_rd   <= 1'b0;
            #1 v = reg_rdata;
        end
    endtask
    // read status until a byte is done, bounded
    task poll;
        integer i;
        begin
            st = 8'h00;
            for (i = 0; i < 60 && st[0] !== 1'b1; i = i + 1)
            begin
                rd(`I2CMS_ADDR_STAT, st);
            end
        end
    endtask
    task rst_dut;
        begin
            @(posedge clk_sys);
            sys_rst <= 1'b1;
            repeat (8) @(posedge clk_sys);
            sys_rst <= 1'b0;
        end
    endtask
    task final_report;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // clock and hang limit
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    // ********************
    // scenarios
    // ********************
    initial
    begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sleep_mode = 1'b0;
        fail_count = 0;
        n_compared = 0;
        cycles = 0;
        rnd = 32'hf5e9;
        rst_dut;
        chk({4'h0, scl_oe, sda_oe, event_pend, wake_req}, 8'h00); // quiet
        for (k = 0; k < 5; k = k + 1)
        begin
            rd(k < 3 ? k[3:0] : (k == 3 ? `I2CMS_ADDR_STAT : 4'hf), d);
            chk(d, exp_rst(reg_addr)); // reset values, unmapped
        end
        // slave: odd passes send an address one bit off
        for (k = 0; k < 4; k = k + 1)
        begin
            rnd = lfsr(rnd);
            own = (k == 2) ? 7'h7f : (rnd[6:0] | 7'h08);
            sent = k[0] ? own ^ (k == 1 ? 7'h01 : 7'h40) : own;
            rst_dut;
            wr(`I2CMS_ADDR_CFG, 8'h01);
            wr(`I2CMS_ADDR_OWN, {1'b0, own});
            i2cms_peer_i.mstart;
            i2cms_peer_i.mbyte(addr_byte(sent, 1'b0), ack);
            chk({7'h0, ack}, {7'h0, k[0]}); // ack on match
            poll;
            chk(st & 8'h07, k[0] ? 8'h00 : 8'h03); // hit flag
            chk({7'h0, scl_oe}, {7'h0, ~k[0]}); // clock held
            chk({7'h0, event_pend}, {7'h0, ~k[0]}); // event line
            if (!k[0])
            begin
                wr(`I2CMS_ADDR_CMD, cmd_xfer);
                i2cms_peer_i.mbyte(rnd[15:8], ack);
                chk({7'h0, ack}, 8'h00); // data acked
                poll;
                rd(`I2CMS_ADDR_DATA, d);
                chk(d, rnd[15:8]); // byte handed over
                wr(`I2CMS_ADDR_CMD, cmd_xfer);
            end
            i2cms_peer_i.mstop;
            rd(`I2CMS_ADDR_STAT, st);
            chk(st & 8'h08, k[0] ? 8'h00 : 8'h08); // stop seen
        end
        // master only: foreign start is ignored
        rst_dut;
        wr(`I2CMS_ADDR_CFG, 8'h02);
        wr(`I2CMS_ADDR_OWN, {1'b0, own});
        i2cms_peer_i.mstart;
        i2cms_peer_i.mbyte(addr_byte(own, 1'b0), ack);
        i2cms_peer_i.mstop;
        rd(`I2CMS_ADDR_STAT, st);
        chk({st[3:0], 2'h0, ack, event_pend}, 8'h02); // no event, no ack
        // address match while asleep
        rst_dut;
        wr(`I2CMS_ADDR_CFG, 8'h01);
        wr(`I2CMS_ADDR_OWN, {1'b0, own});
        i2cms_peer_i.glitch;
        repeat (8) @(posedge clk_sys);
        rd(`I2CMS_ADDR_STAT, st);
        chk(st & 8'h20, 8'h00); // glitch gives no start
        @(posedge clk_sys) sleep_mode <= 1'b1;
        i2cms_peer_i.mstart;
        i2cms_peer_i.mbyte(addr_byte(own, 1'b0), ack);
        repeat (8) @(negedge clk_sys);
        chk({7'h0, wake_req}, 8'h01); // wake on match
        @(posedge clk_sys) sleep_mode <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk({7'h0, wake_req}, 8'h00); // cleared awake
        wr(`I2CMS_ADDR_CMD, cmd_xfer);
        i2cms_peer_i.mstop;
        // master write of address and one data byte, then repeated start
        rst_dut;
        wr(`I2CMS_ADDR_CFG, 8'h02);
        wr(`I2CMS_ADDR_DIV, 8'h08);
        rnd = lfsr(rnd);
        fork
            i2cms_peer_i.sbyte(1'b1, d);
            begin
                wr(`I2CMS_ADDR_DATA, addr_byte(rnd[6:0], 1'b0));
                wr(`I2CMS_ADDR_CMD, cmd_start);
            end
        join
        chk(d, addr_byte(rnd[6:0], 1'b0)); // address then direction
        poll;
        chk(st & 8'h81, 8'h81); // master byte done
        fork
            i2cms_peer_i.sbyte(1'b0, d);
            begin
                wr(`I2CMS_ADDR_DATA, rnd[23:16]);
                wr(`I2CMS_ADDR_CMD, cmd_xfer);
            end
        join
        chk(d, rnd[23:16]); // data byte
        poll;
        // repeated start towards a second address, read direction
        fork
            i2cms_peer_i.sbyte(1'b1, d);
            begin
                wr(`I2CMS_ADDR_DATA, addr_byte(rnd[30:24], 1'b1));
                wr(`I2CMS_ADDR_CMD, cmd_start);
            end
        join
        chk(d, addr_byte(rnd[30:24], 1'b1)); // repeated start address
        poll;
        chk(st & 8'hc1, 8'hc1); // read direction kept
        fork
            i2cms_peer_i.sstop;
            wr(`I2CMS_ADDR_CMD, cmd_stop);
        join
        @(negedge clk_sys);
        chk({6'h0, scl_oe, sda_oe}, 8'h00); // bus freed
        final_report;
    end
endmodule
